//--- include/dbirq_params.svh
// Address map, field positions, reset values and vector code of the drive bridge interrupt block
`ifndef DBIRQ_PARAMS_SVH
`define DBIRQ_PARAMS_SVH

// ----------------------------------------
// Register addresses on the XDATA bus
// ----------------------------------------
`define DBIRQ_ADDR_PRI_STATUS  16'hF0E6
`define DBIRQ_ADDR_PRI_ENABLE  16'hF0E7
`define DBIRQ_ADDR_SEC_STATUS  16'hF0E8
`define DBIRQ_ADDR_SEC_ENABLE  16'hF0E9

// ----------------------------------------
// Primary status field positions
// ----------------------------------------
`define DBIRQ_BIT_DRIVE_IRQ    0
`define DBIRQ_BIT_SEC_PEND     1
`define DBIRQ_BIT_BYTE_MIS     2
`define DBIRQ_BIT_HOST_DONE    3
`define DBIRQ_BIT_HOST_STALL   4
`define DBIRQ_BIT_DRIVE_DONE   5
`define DBIRQ_BIT_AUTO_ERR     6
`define DBIRQ_BIT_CMD_DONE     7

// ----------------------------------------
// Reset values and vector code
// ----------------------------------------
`define DBIRQ_RST_STATUS       8'h00
`define DBIRQ_RST_ENABLE       8'h00
`define DBIRQ_RST_RDATA        8'h00
`define DBIRQ_BRIDGE_VECTOR    8'h48
`define DBIRQ_NO_VECTOR        8'h00

`endif

//--- include/dbirq_pkg.sv
// Types shared by the drive bridge interrupt block
`default_nettype none

package dbirq_pkg;

   // Register selected by the XDATA address decoder
   typedef enum logic [2:0] {
      DBIRQ_SEL_NONE   = 3'b000,
      DBIRQ_SEL_PSTAT  = 3'b001,
      DBIRQ_SEL_PENA   = 3'b010,
      DBIRQ_SEL_SSTAT  = 3'b011,
      DBIRQ_SEL_SENA   = 3'b100
   } dbirq_sel_t;

endpackage

`default_nettype wire

//--- rtl/dbirq_sync.sv
// Two-stage synchroniser with rising-edge pulse for an asynchronous pin
`default_nettype none

module dbirq_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Pin side
   input  wire logic pin_in,
   // Logic side
   output logic      level_out,
   output logic      rise_out
);

   logic meta_ff;
   logic sync_ff;
   logic prev_ff;

   // --------------------------------
   // Synchroniser chain
   // --------------------------------
   // Only sync_ff reads meta_ff; everything else looks downstream
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         meta_ff <= pin_in;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   // Level and edge seen by the block
   assign level_out = sync_ff;
   assign rise_out  = sync_ff & ~prev_ff;

endmodule // dbirq_sync

`default_nettype wire

//--- rtl/dbirq_flag_bank.sv
// Bank of sticky event flags with write-one-to-clear and hardware auto-clear
`default_nettype none

module dbirq_flag_bank #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // Events and clears
   input  wire logic [W-1:0] set_in,
   input  wire logic [W-1:0] w1c_in,
   input  wire logic [W-1:0] auto_clr_in,
   // Flags
   output logic      [W-1:0] flag_out
);

   // --------------------------------
   // One flag per bit
   // --------------------------------
   // A set in the same cycle as a clear wins, so no event is lost
   for (genvar i = 0; i < W; i++) begin : g_flag
      logic flag_ff;
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            flag_ff <= 1'b0;
         end else if (set_in[i]) begin
            flag_ff <= 1'b1;
         end else if (w1c_in[i] || auto_clr_in[i]) begin
            flag_ff <= 1'b0;
         end
      end
      assign flag_out[i] = flag_ff;
   end

endmodule // dbirq_flag_bank

`default_nettype wire

//--- rtl/dbirq_top.sv
// Primary and secondary interrupt status and enable registers of the drive bridge
//
// Operation
// - Drive flag set only in manual phase
// - Automatic phase: hardware absorbs drive interrupt
// - Bit 1 summarises enabled secondary sources
// - Bit 2 set on byte count mismatch
// - Bit 3 set on host-side done
// - Bit 4 set on host-side stalled transfer
// - Clearing bit 4 flushes or forwards buffer
// - Bit 5 set on drive-side done
// - Bit 6 set on auto-sequence error
// - Bit 7 set on clean completion
// - Enabled sources except bit 0 use vector 48h
// - Primary enable register is read/write
// - Secondary status register at F0E8
// - Secondary enable register at F0E9
// - Write one clears flag, zero keeps
// - Launch clears both done flags
// - Primary status F0E6, enable F0E7
`default_nettype none
`include "dbirq_params.svh"

module dbirq_top
   import dbirq_pkg::*;
#(
   parameter int SEC_W = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // XDATA register port
   input  wire logic [15:0]      xaddr,
   input  wire logic [7:0]       xwdata,
   input  wire logic             xwr,
   input  wire logic             xrd,
   output logic      [7:0]       xrdata,
   // Drive interrupt pin
   input  wire logic             drive_intrq,
   // Sequencer state and events
   input  wire logic             manual_phase,
   input  wire logic             byte_count_mismatch,
   input  wire logic             host_side_done,
   input  wire logic             host_side_stalled,
   input  wire logic             drive_side_done,
   input  wire logic             auto_sequence_error,
   input  wire logic             command_completed,
   input  wire logic             launch_transfer,
   input  wire logic             host_pending_abort_select,
   // Secondary sources
   input  wire logic [SEC_W-1:0] secondary_events,
   // Interrupt outputs
   output logic                  bridge_irq,
   output logic      [7:0]       irq_vector,
   output logic                  drive_irq,
   output logic                  secondary_source_pending,
   // Sequencer hand-backs
   output logic                  drive_irq_serviced,
   output logic                  sector_flush,
   output logic                  sector_forward
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   // Bus decode and write strobes
   dbirq_sel_t       sel;
   logic             wr_pstat;
   logic             wr_pena;
   logic             wr_sstat;
   logic             wr_sena;
   // Drive pin edge
   logic             intrq_rise;
   // Flag banks and enables
   logic [6:0]       pri_set;
   logic [6:0]       pri_w1c;
   logic [6:0]       pri_auto;
   logic [6:0]       pri_flags;
   logic [7:0]       pri_status;
   logic [7:0]       pri_enable_ff;
   logic [SEC_W-1:0] sec_w1c;
   logic [SEC_W-1:0] sec_flags;
   logic [SEC_W-1:0] sec_enable_ff;
   logic [7:0]       pri_pending;
   // Stall resolution, hand-backs and read path
   logic             stall_clear;
   logic             serviced_ff;
   logic             flush_ff;
   logic             forward_ff;
   logic [7:0]       rdata_ff;
   logic [7:0]       nxt_rdata;
   logic [7:0]       sec_rd;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // Only the four addresses below answer; anything else reads zero
   // The address is decoded in full, so no register shows up at a mirror
   always_comb begin
      case (xaddr)
         `DBIRQ_ADDR_PRI_STATUS: sel = DBIRQ_SEL_PSTAT;
         `DBIRQ_ADDR_PRI_ENABLE: sel = DBIRQ_SEL_PENA;
         `DBIRQ_ADDR_SEC_STATUS: sel = DBIRQ_SEL_SSTAT;
         `DBIRQ_ADDR_SEC_ENABLE: sel = DBIRQ_SEL_SENA;
         default:                sel = DBIRQ_SEL_NONE;
      endcase
   end

   // Write strobes per register
   // A strobe held for several cycles repeats the write, which is harmless
   assign wr_pstat = xwr && (sel == DBIRQ_SEL_PSTAT);
   assign wr_pena  = xwr && (sel == DBIRQ_SEL_PENA);
   assign wr_sstat = xwr && (sel == DBIRQ_SEL_SSTAT);
   assign wr_sena  = xwr && (sel == DBIRQ_SEL_SENA);

   // ----------------------------------------
   // Drive interrupt pin
   // ----------------------------------------
   // Two flops guard against a metastable pin sample; only the rising
   // edge is an event, so the synchronised level is left unconnected
   dbirq_sync u_intrq_sync (
      .clk       (clk),
      .resetn    (resetn),
      .pin_in    (drive_intrq),
      .level_out (),
      .rise_out  (intrq_rise)
   );

   // Hardware takes the drive interrupt itself outside the manual phase
   // The pulse tells the sequencer the edge was consumed; no flag is set,
   // so firmware is not disturbed while the automatic phase runs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         serviced_ff <= 1'b0;
      end else begin
         serviced_ff <= intrq_rise && !manual_phase;
      end
   end

   // ----------------------------------------
   // Primary status flags
   // ----------------------------------------
   // Bank order: {cmd_done, auto_err, drive_done, host_stall, host_done,
   // byte_mis, drive_irq}; bit 1 has no flop, it is a live summary
   // Event inputs set their flag in every cycle they are high, so a clear
   // only sticks once the source has dropped again
   assign pri_set[0] = intrq_rise && manual_phase;
   assign pri_set[1] = byte_count_mismatch;
   assign pri_set[2] = host_side_done;
   assign pri_set[3] = host_side_stalled;
   assign pri_set[4] = drive_side_done;
   assign pri_set[5] = auto_sequence_error;
   assign pri_set[6] = command_completed;

   // Ones written to the status address clear, zeros keep
   // Written bit 1 is dropped: it is read-only and has no flop to clear
   assign pri_w1c = wr_pstat ? {xwdata[7:2], xwdata[0]} : 7'h00;

   // A new transfer launch drops both done flags
   // A done event in the launch cycle still wins, so no completion is lost
   always_comb begin
      pri_auto    = 7'h00;
      pri_auto[2] = launch_transfer;
      pri_auto[4] = launch_transfer;
   end

   // Seven flops: bit 1 of the register is the summary, not a flag
   dbirq_flag_bank #(
      .W (7)
   ) u_pri_bank (
      .clk         (clk),
      .resetn      (resetn),
      .set_in      (pri_set),
      .w1c_in      (pri_w1c),
      .auto_clr_in (pri_auto),
      .flag_out    (pri_flags)
   );

   // Full 8-bit view with the summary bit in place
   // Reads and the request logic use the same view, so they never disagree
   assign pri_status = {pri_flags[6:1], secondary_source_pending, pri_flags[0]};

   // ----------------------------------------
   // Primary enable register
   // ----------------------------------------
   // All eight bits are kept; bit 0 gates the drive line, bit 1 the summary
   // A changed mask acts from the next cycle and never touches a flag
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pri_enable_ff <= `DBIRQ_RST_ENABLE;
      end else if (wr_pena) begin
         pri_enable_ff <= xwdata;
      end
   end

   // ----------------------------------------
   // Secondary status and enable
   // ----------------------------------------
   // Ones written to the secondary status clear, zeros keep
   assign sec_w1c = wr_sstat ? xwdata[SEC_W-1:0] : '0;

   dbirq_flag_bank #(
      .W (SEC_W)
   ) u_sec_bank (
      .clk         (clk),
      .resetn      (resetn),
      .set_in      (secondary_events),
      .w1c_in      (sec_w1c),
      .auto_clr_in ('0),
      .flag_out    (sec_flags)
   );

   // Secondary enable register, read and write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sec_enable_ff <= '0;
      end else if (wr_sena) begin
         sec_enable_ff <= xwdata[SEC_W-1:0];
      end
   end

   // Any enabled secondary source lights the summary bit
   // It is live, so it drops as soon as the last enabled source is cleared
   assign secondary_source_pending = |(sec_flags & sec_enable_ff);

   // ----------------------------------------
   // Stalled-transfer resolution
   // ----------------------------------------
   // Firmware must have set the abort select before this write; the
   // select is sampled in the clearing cycle. A clear beaten by a new
   // stall event does not count, since the flag stays set.
   assign stall_clear = wr_pstat && xwdata[`DBIRQ_BIT_HOST_STALL]
                        && pri_flags[3] && !pri_set[3];

   // Exclusive one-cycle pulses; the select's polarity is 1 = flush
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flush_ff   <= 1'b0;
         forward_ff <= 1'b0;
      end else begin
         flush_ff   <= stall_clear && host_pending_abort_select;
         forward_ff <= stall_clear && !host_pending_abort_select;
      end
   end

   // ----------------------------------------
   // Interrupt request and vector
   // ----------------------------------------
   // A flag only requests while its enable bit is set
   assign pri_pending = pri_status & pri_enable_ff;

   // Bit 0 requests on its own line; the rest share the bridge vector
   assign bridge_irq = |pri_pending[7:1];
   assign irq_vector = bridge_irq ? `DBIRQ_BRIDGE_VECTOR : `DBIRQ_NO_VECTOR;
   assign drive_irq  = pri_pending[`DBIRQ_BIT_DRIVE_IRQ];

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // Narrow secondary widths read as zero above the top source
   always_comb begin
      sec_rd = 8'h00;
      sec_rd[SEC_W-1:0] = sec_flags;
   end

   // Register mux ahead of the read flop; unmapped addresses read zero
   always_comb begin
      case (sel)
         DBIRQ_SEL_PSTAT: nxt_rdata = pri_status;
         DBIRQ_SEL_PENA:  nxt_rdata = pri_enable_ff;
         DBIRQ_SEL_SSTAT: nxt_rdata = sec_rd;
         DBIRQ_SEL_SENA: begin
            nxt_rdata = 8'h00;
            nxt_rdata[SEC_W-1:0] = sec_enable_ff;
         end
         default:         nxt_rdata = `DBIRQ_RST_RDATA;
      endcase
   end

   // Read data is captured on the read strobe and held until the next read
   // Holding it lets a slow master sample late, at the cost of stale data
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= `DBIRQ_RST_RDATA;
      end else if (xrd) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Hand-backs come straight from flops, so the sequencer sees clean pulses
   assign xrdata             = rdata_ff;
   assign drive_irq_serviced = serviced_ff;
   assign sector_flush       = flush_ff;
   assign sector_forward     = forward_ff;

endmodule // dbirq_top

`default_nettype wire

//--- sim/dbirq_top_monitor.sv
// Port-level concurrent checks for the drive bridge interrupt block
`default_nettype none

module dbirq_top_monitor (
   // Clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // Register port
   input wire logic [15:0] xaddr,
   input wire logic [7:0]  xwdata,
   input wire logic        xwr,
   input wire logic        xrd,
   input wire logic [7:0]  xrdata,
   // Pin and sequencer
   input wire logic        drive_intrq,
   input wire logic        manual_phase,
   input wire logic        host_side_done,
   input wire logic        drive_side_done,
   input wire logic        auto_sequence_error,
   input wire logic        command_completed,
   input wire logic        launch_transfer,
   input wire logic        host_pending_abort_select,
   // Outputs
   input wire logic        bridge_irq,
   input wire logic [7:0]  irq_vector,
   input wire logic        drive_irq,
   input wire logic        secondary_source_pending,
   input wire logic        drive_irq_serviced,
   input wire logic        sector_flush,
   input wire logic        sector_forward
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // ------------------------------------------------------------
   // Helper logic
   // ------------------------------------------------------------
   // Enable shadow rebuilt from port writes, since the register is internal
   logic [7:0] en_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) en_ff <= 8'h00;
      else if (xwr && xaddr == 16'hF0E7) en_ff <= xwdata;
   end
   wire logic clr4 = xwr && xaddr == 16'hF0E6 && xwdata[4];

   // Pin rise seen with the phase held steady through the synchroniser
   sequence rise_auto;
      $rose(drive_intrq) && !manual_phase ##1 !manual_phase[*2];
   endsequence
   sequence rise_manual;
      $rose(drive_intrq) && manual_phase && en_ff[0] ##1 manual_phase[*2];
   endsequence

   a_vector_code: assert property (irq_vector == (bridge_irq ? 8'h48 : 8'h00))
      else $error("vector does not follow request");
   a_done_raises_irq: assert property (command_completed && en_ff[7] |=> bridge_irq)
      else $error("completion did not raise request");
   a_error_sets_vector: assert property (auto_sequence_error && en_ff[6]
      |=> irq_vector == 8'h48)
      else $error("auto error did not give vector");
   a_summary_irq: assert property (secondary_source_pending && en_ff[1] |-> bridge_irq)
      else $error("secondary summary not requested");
   a_auto_serviced: assert property (rise_auto |-> ##[1:2] drive_irq_serviced)
      else $error("automatic phase pin edge not serviced");
   a_manual_flag: assert property (rise_manual |-> ##[1:2] drive_irq)
      else $error("manual phase pin edge not flagged");
   a_manual_quiet: assert property (manual_phase[*4] |-> !drive_irq_serviced)
      else $error("service pulse during manual phase");
   a_flush_cause: assert property (sector_flush |-> $past(clr4 && host_pending_abort_select))
      else $error("flush without clearing write");
   a_forward_cause: assert property (sector_forward
      |-> $past(clr4 && !host_pending_abort_select))
      else $error("forward without clearing write");
   a_launch_clears: assert property (launch_transfer && en_ff == 8'h28 && !host_side_done
      && !drive_side_done |=> !bridge_irq)
      else $error("launch left done flags set");
   a_unmapped_zero: assert property (xrd && (xaddr < 16'hF0E6 || xaddr > 16'hF0E9)
      |=> xrdata == 8'h00)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property ($rose(resetn) |-> !bridge_irq && xrdata == 8'h00)
      else $error("outputs active after reset");
endmodule // dbirq_top_monitor

bind dbirq_top dbirq_top_monitor u_mon (
   .clk(clk), .resetn(resetn), .xaddr(xaddr), .xwdata(xwdata), .xwr(xwr), .xrd(xrd),
   .xrdata(xrdata), .drive_intrq(drive_intrq), .manual_phase(manual_phase),
   .host_side_done(host_side_done), .drive_side_done(drive_side_done),
   .auto_sequence_error(auto_sequence_error), .command_completed(command_completed),
   .launch_transfer(launch_transfer), .host_pending_abort_select(host_pending_abort_select),
   .bridge_irq(bridge_irq), .irq_vector(irq_vector), .drive_irq(drive_irq),
   .secondary_source_pending(secondary_source_pending),
   .drive_irq_serviced(drive_irq_serviced), .sector_flush(sector_flush),
   .sector_forward(sector_forward));

`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the drive bridge interrupt block
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0, resetn = 1'b0, xwr = 1'b0, xrd = 1'b0;
   logic        pin = 1'b0, manual = 1'b0, launch = 1'b0, sel = 1'b0;
   logic [15:0] xaddr = 16'h0000;
   logic [7:0]  xwdata = 8'h00, sec = 8'h00, xrdata, irq_vector, b, s;
   logic [5:0]  evt = 6'h00;
   logic        birq, dirq, spend, serv, flush, fwd;
   logic [7:0]  q[$];
   int          failures = 0, checks = 0, seed = 12, r;

   always #4 clk = ~clk;

   dbirq_top dut (
      .clk(clk), .resetn(resetn), .xaddr(xaddr), .xwdata(xwdata), .xwr(xwr), .xrd(xrd),
      .xrdata(xrdata), .drive_intrq(pin), .manual_phase(manual),
      .byte_count_mismatch(evt[0]), .host_side_done(evt[1]), .host_side_stalled(evt[2]),
      .drive_side_done(evt[3]), .auto_sequence_error(evt[4]), .command_completed(evt[5]),
      .launch_transfer(launch), .host_pending_abort_select(sel), .secondary_events(sec),
      .bridge_irq(birq), .irq_vector(irq_vector), .drive_irq(dirq),
      .secondary_source_pending(spend), .drive_irq_serviced(serv),
      .sector_flush(flush), .sector_forward(fwd));

   // ------------------------------------------------------------
   // Bus tasks and checking
   // ------------------------------------------------------------
   task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One-cycle strobes; the idle cycle after each keeps strobes from merging
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(negedge clk);
      xaddr = a;
      xwdata = d;
      xwr = 1'b1;
      @(negedge clk);
      xwr = 1'b0;
   endtask

   task automatic rd(logic [15:0] a, logic [7:0] e);
      @(negedge clk);
      xaddr = a;
      xrd = 1'b1;
      q.push_back(e);
      @(negedge clk);
      xrd = 1'b0;
   endtask

   task automatic ev(int n);
      @(negedge clk);
      evt[n] = 1'b1;
      @(negedge clk);
      evt = 6'h00;
   endtask

   // Read data lands on the strobe edge and is checked at the next falling edge
   always @(posedge clk) begin
      if (xrd === 1'b1) begin
         @(negedge clk);
         cmp("xrdata", q.pop_front(), xrdata);
      end
   end

   // Hang guard, far beyond the roughly 140 cycles the sequence needs
   initial begin
      #50000;
      failures++;
      complete_run();
   end

   initial begin
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      for (int a = 16'hF0E6; a <= 16'hF0EA; a++) rd(a[15:0], 8'h00);
      wr(16'hF0E7, 8'hFF);
      wr(16'hF0E9, 8'hFF);
      rd(16'hF0E7, 8'hFF);
      rd(16'hF0E9, 8'hFF);
      // Each event flag: set, survive zero writes, clear by one
      for (int i = 0; i < 6; i++) begin
         b = 8'h04 << i;
         r = $random(seed);
         sel = r[0];
         ev(i);
         cmp("vector", 8'h48, irq_vector);
         wr(16'hF0E6, ~b & 8'hFD);
         rd(16'hF0E6, b);
         wr(16'hF0E6, b);
         cmp("pulses", {6'h00, i == 2 && sel, i == 2 && !sel}, {6'h00, flush, fwd});
         rd(16'hF0E6, 8'h00);
      end
      // Second stall with the opposite select, so flush and forward both occur
      sel = ~sel;
      ev(2);
      wr(16'hF0E6, 8'h10);
      cmp("pulses", {6'h00, sel, !sel}, {6'h00, flush, fwd});
      // Secondary sources fold into the summary bit
      r = $random(seed);
      s = r[7:0] | 8'h01;
      @(negedge clk) sec = s;
      @(negedge clk) sec = 8'h00;
      rd(16'hF0E8, s);
      rd(16'hF0E6, 8'h02);
      cmp("vector", 8'h48, irq_vector);
      wr(16'hF0E8, s);
      rd(16'hF0E8, 8'h00);
      // Drive pin in manual phase, then in automatic phase
      @(negedge clk) manual = 1'b1;
      pin = 1'b1;
      repeat (5) @(negedge clk);
      cmp("drive_irq", 8'h01, {7'h00, dirq});
      cmp("vector", 8'h00, irq_vector);
      rd(16'hF0E6, 8'h01);
      wr(16'hF0E6, 8'h01);
      pin = 1'b0;
      manual = 1'b0;
      repeat (4) @(negedge clk);
      pin = 1'b1;
      repeat (3) @(negedge clk);
      cmp("serviced", 8'h01, {7'h00, serv});
      repeat (2) @(negedge clk);
      rd(16'hF0E6, 8'h00);
      pin = 1'b0;
      // Launch clears only the two done flags
      wr(16'hF0E7, 8'h28);
      ev(1);
      ev(3);
      ev(5);
      rd(16'hF0E6, 8'hA8);
      @(negedge clk) launch = 1'b1;
      @(negedge clk) launch = 1'b0;
      rd(16'hF0E6, 8'h80);
      cmp("vector", 8'h00, irq_vector);
      // Second reset in mid-run
      @(negedge clk) resetn = 1'b0;
      @(negedge clk) resetn = 1'b1;
      rd(16'hF0E6, 8'h00);
      rd(16'hF0E7, 8'h00);
      repeat (2) @(negedge clk);
      complete_run();
   end
endmodule // tb_top

`default_nettype wire
